/* File: design/rom_boot_loader.sv */
// boot loader of configuration bytes and expansion-rom fetch path
// Behaviour
// [R1] boot range is memory bytes 0x40 to 0x7f
// [R2] each mapped byte lands in its configuration field by offset
// [R3] image writer puts 0x80, 0x81 or 0x82 at 0x50
// [R4] image writer puts 0xff at 0x51, fixed codes at 0x52, 0x53
// [R5] four base address words from 0x54..0x60, rom base from 0x70
// [R6] image starts with signature 0x55 then 0xaa
// [R7] byte 0x02 gives image length in 512-byte units
// [R8] four-byte init entry point starts at 0x03
// [R9] host runs rom only with valid header and checksum
// [R10] checksum byte sits at end of declared length
// [R11] 16-bit pointer at 0x18 locates bus data structure
// [R12] data structure opens with ascii signature in order
// [R13] data structure revision byte at 0x0c is zero
// [R14] indicator bit 7 at 0x15 marks the last image
// [R15] rom reads are slow; one byte per serial access
// [R16] rom read retries until all four bytes are fetched; the code instead stalls bus requests on waitrequest during the fetch
// [R17] configuration reads wait until boot load completes
module rom_boot_loader
	import rom_boot_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// register bus
	input wire av_req_t av_req,
	output av_rsp_t av_rsp,
	// serial memory byte port
	output mem_req_t mem_req,
	input wire mem_rsp_t mem_rsp,
	// loaded configuration
	output logic boot_done,
	output logic [31:0] id_word,
	output logic [31:0] class_word,
	output logic [7:0] special_modes,
	output logic [31:0] bar_word [4],
	output logic [31:0] rom_bar_word,
	output logic [31:0] sub_word,
	output logic [15:0] int_word
);
	typedef enum {st_boot, st_idle, st_fetch, st_answer} fsm_t;
	typedef struct packed {
		fsm_t st;
		logic [63:0][7:0] cfg;
		logic [10:0] addr;
		logic [1:0] nbyte;
		logic [31:0] rom_data;
		logic retry;
		logic [15:0] fetches;
		logic [31:0] rdata;
		logic wait_n;
		logic mreq;
	} state_t;
	state_t s_q, s_d;

	function automatic logic [31:0] word_at(input state_t s, input logic [6:0] off);
		word_at = {s.cfg[6'(off + 7'd3)], s.cfg[6'(off + 7'd2)],
			s.cfg[6'(off + 7'd1)], s.cfg[6'(off)]};
	endfunction

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.wait_n = 1'b0;
		case (s_q.st)
			st_boot: begin
				s_d.mreq = 1'b1;
				if (mem_rsp.valid) begin
					s_d.cfg[6'(s_q.addr)] = mem_rsp.data; // see [R2]
					if (s_q.addr == boot_last) begin // see [R1]
						s_d.mreq = 1'b0;
						s_d.st = st_idle; // see [R17]
					end else begin
						s_d.addr = 11'(s_q.addr + 11'd1);
					end
				end
			end
			st_idle: begin
				if (av_req.read || av_req.write) begin
					s_d.wait_n = 1'b1;
					s_d.rdata = unmapped_val;
					case (av_req.address)
						reg_status: s_d.rdata = {30'h0, s_q.retry, 1'b1};
						reg_rom_data: s_d.rdata = s_q.rom_data;
						reg_fetch_cnt: s_d.rdata = {16'h0, s_q.fetches};
						reg_rom_ctrl: begin
							if (av_req.write) begin
								// starts a four-byte fetch; meanwhile requests stall on waitrequest
								s_d.addr = {av_req.writedata[10:2], 2'b00};
								s_d.nbyte = 2'd0;
								s_d.retry = 1'b1; // see [R16]
								s_d.mreq = 1'b1;
								s_d.st = st_fetch;
							end
							s_d.rdata = {21'h0, s_q.addr};
						end
						default: s_d.rdata = unmapped_val;
					endcase
					if (av_req.read && av_req.address == reg_rom_data && s_q.retry)
						s_d.rdata = unmapped_val; // see [R16]
				end
			end
			st_fetch: begin
				if (mem_rsp.valid) begin
					// one byte per serial access keeps rom reads slow
					s_d.rom_data[8*s_q.nbyte +: 8] = mem_rsp.data; // see [R15]
					s_d.addr = 11'(s_q.addr + 11'd1);
					s_d.nbyte = 2'(s_q.nbyte + 2'd1);
					if (s_q.nbyte == 2'd3) begin
						s_d.mreq = 1'b0;
						s_d.retry = 1'b0; // see [R16]
						s_d.fetches = 16'(s_q.fetches + 16'd1);
						s_d.st = st_idle;
					end
				end
			end
			st_answer: s_d.st = st_idle;
			default: s_d.st = st_idle;
		endcase
		if (s_q.wait_n)
			s_d.wait_n = 1'b0;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '0;
			s_q.st <= st_boot;
			s_q.addr <= boot_first;
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			boot_done <= 1'b0;
			id_word <= rst_word;
			class_word <= rst_word;
			special_modes <= 8'h00;
			bar_word <= '{default: rst_word};
			rom_bar_word <= rst_word;
			sub_word <= rst_word;
			int_word <= 16'h0000;
		end else if (s_q.st != st_boot) begin
			// fields stay at reset value until the load is whole
			boot_done <= 1'b1; // see [R17]
			id_word <= word_at(s_q, off_vendor);
			class_word <= {s_q.cfg[6'(off_class + 7'd2)], s_q.cfg[6'(off_class + 7'd1)],
				s_q.cfg[6'(off_class)], s_q.cfg[6'(off_revision)]}; // see [R2]
			special_modes <= s_q.cfg[6'(off_modes)];
			bar_word[0] <= word_at(s_q, off_bar1); // see [R5]
			bar_word[1] <= word_at(s_q, off_bar2);
			bar_word[2] <= word_at(s_q, off_bar3);
			bar_word[3] <= word_at(s_q, off_bar4);
			rom_bar_word <= word_at(s_q, off_rom_bar); // see [R5]
			sub_word <= {s_q.cfg[6'(off_sub_product + 7'd1)], s_q.cfg[6'(off_sub_product)],
				s_q.cfg[6'(off_sub_vendor + 7'd1)], s_q.cfg[6'(off_sub_vendor)]};
			int_word <= {s_q.cfg[6'(off_int_pin)], s_q.cfg[6'(off_int_line)]};
		end
	end

	assign av_rsp.readdata = s_q.rdata;
	assign av_rsp.waitrequest = !s_q.wait_n;
	assign mem_req.req = s_q.mreq;
	assign mem_req.addr = s_q.addr;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_boot_range;
		@(posedge clk) disable iff (!rstn)
		(s_q.st == st_boot) |-> (s_q.addr >= boot_first && s_q.addr <= boot_last);
	endproperty
	a_boot_range: assert property (p_boot_range) else $error("boot address out of range"); // see [R1]

	property p_done_hold;
		@(posedge clk) disable iff (!rstn)
		boot_done |=> boot_done;
	endproperty
	a_done_hold: assert property (p_done_hold) else $error("boot done dropped"); // see [R17]

	property p_done_after;
		@(posedge clk) disable iff (!rstn)
		boot_done |-> $past(s_q.st) != st_boot;
	endproperty
	a_done_after: assert property (p_done_after) else $error("done before load"); // see [R17]

	property p_bar_load;
		@(posedge clk) disable iff (!rstn)
		$rose(boot_done) |-> rom_bar_word == $past(word_at(s_q, off_rom_bar));
	endproperty
	a_bar_load: assert property (p_bar_load) else $error("rom base word wrong"); // see [R5]

	property p_retry_data;
		@(posedge clk) disable iff (!rstn)
		(s_q.st == st_fetch) |-> s_q.retry;
	endproperty
	a_retry_data: assert property (p_retry_data) else $error("data given before fetch"); // see [R16]

	property p_fetch_end;
		@(posedge clk) disable iff (!rstn)
		(s_q.st == st_fetch && mem_rsp.valid && s_q.nbyte == 2'd3) |=> !s_q.retry;
	endproperty
	a_fetch_end: assert property (p_fetch_end) else $error("retry stuck after fetch"); // see [R16]

	property p_boot_store;
		@(posedge clk) disable iff (!rstn)
		(s_q.st == st_boot && mem_rsp.valid) |=> s_q.cfg[6'($past(s_q.addr))] == $past(mem_rsp.data);
	endproperty
	a_boot_store: assert property (p_boot_store) else $error("boot byte misplaced"); // see [R2]

	property p_answer_one;
		@(posedge clk) disable iff (!rstn)
		!av_rsp.waitrequest |=> av_rsp.waitrequest;
	endproperty
	a_answer_one: assert property (p_answer_one) else $error("answer longer than one cycle"); // see [R15]
endmodule // rom_boot_loader

/* File: dv/mem_model.sv */
// serial memory model holding the boot image
module mem_model
	import rom_boot_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// pacing and byte port
	input wire logic slow,
	input wire mem_req_t mem_req,
	output mem_rsp_t mem_rsp
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt;
	function automatic logic [7:0] img(input logic [10:0] a);
		case (a)
			11'h000: return 8'h55;
			11'h001: return 8'haa;
			11'h002: return 8'h01;
			11'h003: return 8'heb;
			11'h018: return 8'h00;
			11'h019: return 8'h01;
			11'h050: return 8'h80;
			11'h051: return 8'hff;
			11'h052: return 8'h5a; // arbitrary code
			11'h053: return 8'ha5; // arbitrary code
			11'h100: return 8'h50;
			11'h101: return 8'h43;
			11'h102: return 8'h49;
			11'h103: return 8'h52;
			11'h10c: return 8'h00;
			11'h115: return 8'h80;
			// host only trusts the image when this byte balances the sum
			11'h1ff: return 8'h00;
			default: return a[7:0] ^ {a[10:8], 5'h15};
		endcase
	endfunction
	// idle data toggles so a stale byte is never mistaken for fresh
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt <= 4'h0;
			mem_rsp <= '0;
		end else if (mem_req.req && cnt >= (slow ? 4'h9 : 4'h1)) begin
			mem_rsp.valid <= 1'b1;
			mem_rsp.data <= img(mem_req.addr);
			cnt <= 4'h0;
		end else begin
			mem_rsp.valid <= 1'b0;
			mem_rsp.data <= ~mem_rsp.data;
			cnt <= mem_req.req ? cnt + 4'h1 : 4'h0;
		end
	end
endmodule // mem_model

/* File: dv/testbench.sv */
// boot loader testbench
module testbench
	import rom_boot_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rstn, slow;
	av_req_t av_req;
	av_rsp_t av_rsp;
	mem_req_t mem_req;
	mem_rsp_t mem_rsp;
	logic boot_done;
	logic [31:0] id_word, class_word, rom_bar_word, sub_word, rd;
	logic [31:0] bar_word [4];
	logic [7:0] special_modes;
	logic [15:0] int_word;
	int num_errors = 0;
	int comparisons = 0;
	int cycles = 0;
	rom_boot_loader DUT (.clk(clk), .rstn(rstn), .av_req(av_req), .av_rsp(av_rsp),
		.mem_req(mem_req), .mem_rsp(mem_rsp), .boot_done(boot_done), .id_word(id_word),
		.class_word(class_word), .special_modes(special_modes), .bar_word(bar_word),
		.rom_bar_word(rom_bar_word), .sub_word(sub_word), .int_word(int_word));
	mem_model mem (.clk(clk), .rstn(rstn), .slow(slow), .mem_req(mem_req), .mem_rsp(mem_rsp));
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] w(input logic [10:0] a);
		return {mem.img(a + 11'h3), mem.img(a + 11'h2), mem.img(a + 11'h1), mem.img(a)};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// request held until waitrequest is sampled low, released at that edge
	task automatic av(input logic [7:0] a, input logic wr, input logic [31:0] wd);
		@(posedge clk);
		av_req <= '{address: a, read: !wr, write: wr, writedata: wd, byteenable: 4'hf};
		do @(posedge clk); while (av_rsp.waitrequest !== 1'b0);
		rd = av_rsp.readdata;
		av_req.read <= 1'b0;
		av_req.write <= 1'b0;
	endtask
	// ------------------------------------------------------------
	// clock, reset, timeout
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			close_out();
		end
	end
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		rstn = 1'b0;
		slow = 1'b0;
		av_req = '0;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		chk(32'(boot_done), 32'h0);
		chk(bar_word[0], 32'h0);
		av(reg_status, 1'b0, 32'h0);
		chk(32'(boot_done), 32'h1);
		chk(rd, 32'h1);
		chk(id_word, w(11'h040));
		chk(class_word, w(11'h048));
		chk(32'(special_modes), 32'(mem.img(11'h045)));
		for (int i = 0; i < 4; i++)
			chk(bar_word[i], w(11'(11'h054 + 4 * i)));
		chk(rom_bar_word, w(11'h070));
		chk(sub_word, w(11'h06c));
		chk(32'(int_word), {16'h0, mem.img(11'h07d), mem.img(11'h07c)});
		for (int k = 0; k < 2; k++) begin
			slow <= k[0];
			av(reg_rom_ctrl, 1'b1, k[0] ? 32'h7fc : 32'h0);
			av(reg_status, 1'b0, 32'h0);
			chk(rd, 32'h1);
			av(reg_rom_data, 1'b0, 32'h0);
			chk(rd, w(k[0] ? 11'h7fc : 11'h000));
			av(reg_fetch_cnt, 1'b0, 32'h0);
			chk(rd, 32'(k + 1));
		end
		av(reg_rom_ctrl, 1'b1, 32'h100);
		av(reg_rom_data, 1'b0, 32'h0);
		chk(rd, 32'h52494350);
		av(reg_fetch_cnt, 1'b0, 32'h0);
		chk(rd, 32'h3);
		av(8'h90, 1'b1, 32'hffffffff);
		av(8'h90, 1'b0, 32'h0);
		chk(rd, unmapped_val);
		close_out();
	end
endmodule // testbench

/* File: inc/rom_boot_pkg.sv */
// constants and carrier types for the serial-memory boot loader
package rom_boot_pkg;
	// ------------------------------------------------------------
	// boot-load byte map
	// ------------------------------------------------------------
	localparam logic [10:0] boot_first = 11'h040;
	localparam logic [10:0] boot_last = 11'h07f;
	localparam logic [6:0] off_vendor = 7'h40;
	localparam logic [6:0] off_device = 7'h42;
	localparam logic [6:0] off_modes = 7'h45;
	localparam logic [6:0] off_revision = 7'h48;
	localparam logic [6:0] off_class = 7'h49;
	localparam logic [6:0] off_header = 7'h4e;
	localparam logic [6:0] off_selftest = 7'h4f;
	localparam logic [6:0] off_bar1 = 7'h54;
	localparam logic [6:0] off_bar2 = 7'h58;
	localparam logic [6:0] off_bar3 = 7'h5c;
	localparam logic [6:0] off_bar4 = 7'h60;
	localparam logic [6:0] off_sub_vendor = 7'h6c;
	localparam logic [6:0] off_sub_product = 7'h6e;
	localparam logic [6:0] off_rom_bar = 7'h70;
	localparam logic [6:0] off_int_line = 7'h7c;
	localparam logic [6:0] off_int_pin = 7'h7d;
	// ------------------------------------------------------------
	// avalon register offsets (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] reg_status = 8'h80;
	localparam logic [7:0] reg_rom_ctrl = 8'h84;
	localparam logic [7:0] reg_rom_data = 8'h88;
	localparam logic [7:0] reg_fetch_cnt = 8'h8c;
	localparam logic [31:0] unmapped_val = 32'h00000000;
	localparam logic [31:0] rst_word = 32'h00000000;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int clk_mhz = 25;
	localparam int byte_time_ns = 480;
	localparam int byte_cycles = (byte_time_ns * clk_mhz + 999) / 1000;
	localparam logic [4:0] byte_cnt_init = 5'(byte_cycles - 1);
	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] address;
		logic read;
		logic write;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} av_req_t;
	typedef struct packed {
		logic [31:0] readdata;
		logic waitrequest;
	} av_rsp_t;
	typedef struct packed {
		logic req;
		logic [10:0] addr;
	} mem_req_t;
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} mem_rsp_t;
endpackage
